// ===== logic/sfci_cmd_if.sv
// Command hand-off between the link and the core
`timescale 1ns/1ps
`default_nettype none
interface sfci_cmd_if;
    logic       tgl;
    logic [7:0] op;
    logic [21:0] addr;
    modport link (output tgl, output op, output addr);
    modport core (input tgl, input op, input addr);
endinterface : sfci_cmd_if
`default_nettype wire

// ===== logic/sfci_link.sv
// Link-clock side: shifts bits in and out on the serial clock
`timescale 1ns/1ps
`default_nettype none
module sfci_link
    import sfci_pkg::*;
(
    input  wire logic       rst,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic [3:0] dq_i,
    output logic [3:0]      dq_o,
    output logic [3:0]      dq_oe,
    input  wire logic       busy,
    sfci_cmd_if.link        cmd
);
    sfci_state_e st_q;
    logic [7:0]  sh_q;
    logic [5:0]  bit_q;
    logic [7:0]  op_q;
    logic [21:0] addr_q;
    logic [2:0]  per_bit;
    logic [7:0]  sh_d;
    logic        quad_q;
    logic        tgl_q;

    // Mode is held on this side so it is settled before the first clock of a frame
    assign per_bit = quad_q ? 3'd4 : 3'd1;
    assign sh_d    = quad_q ? {sh_q[3:0], dq_i} : {sh_q[6:0], dq_i[0]};

    function automatic logic op_valid(input logic [7:0] o, input logic q);
        op_valid = (o == OP_WREN) || (o == OP_WRDI) || (o == OP_STATUS_READ_CMD) || (o == OP_STATUS_WRITE_CMD)
                || (o == OP_READ && !q) || (o == OP_FREAD) || (o == OP_PP)
                || (o == OP_SE) || (o == OP_BE32) || (o == OP_BE) || (o == OP_CE)
                || (o == OP_CE2) || (o == OP_QEN && !q) || (o == OP_QEX && q);
    endfunction : op_valid

    ////////////////////////////////////////////////////////////////////////////
    // Sampling on rising edges; chip select high clears the frame
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            st_q   <= SFCI_OPCODE;
            sh_q   <= 8'h00;
            bit_q  <= 6'd0;
            op_q   <= 8'h00;
            addr_q <= 22'h00_0000;
        end else begin
            sh_q  <= sh_d;
            bit_q <= bit_q + 6'(per_bit);
            case (st_q)
                SFCI_OPCODE: begin
                    if (bit_q + 6'(per_bit) == 6'd8) begin
                        op_q <= sh_d;
                        st_q <= op_valid(sh_d, quad_q) ? SFCI_ACTIVE
                                                          : SFCI_STANDBY;
                    end
                end
                SFCI_ACTIVE: begin
                    // One address byte per byte boundary, top two bits fall off
                    if (bit_q < 6'd32 && ((bit_q + 6'(per_bit)) & 6'h07) == 6'h00)
                        addr_q <= {addr_q[13:0], sh_d};
                end
                SFCI_STANDBY: st_q <= SFCI_STANDBY;
                default: st_q <= SFCI_STANDBY;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data launched on falling edges; quiet outside active status reads
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            dq_o  <= 4'h0;
            dq_oe <= 4'h0;
        end else begin
            dq_o <= quad_q ? {4{busy}} : {2'b00, busy, 1'b0};
            if (st_q == SFCI_ACTIVE && op_q == OP_STATUS_READ_CMD && bit_q >= 6'd8)
                dq_oe <= quad_q ? 4'hF : 4'h2;
            else
                dq_oe <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command completes at chip-select rise, only on a byte boundary
    always_ff @(posedge cs_n or posedge rst) begin
        if (rst) begin
            tgl_q    <= 1'b0;
            quad_q   <= 1'b0;
            cmd.op   <= 8'h00;
            cmd.addr <= 22'h00_0000;
        end else if (st_q == SFCI_ACTIVE && bit_q[2:0] == 3'd0) begin
            tgl_q    <= ~tgl_q;
            cmd.op   <= op_q;
            cmd.addr <= addr_q;
            if (op_q == OP_QEN) quad_q <= 1'b1;
            if (op_q == OP_QEX) quad_q <= 1'b0;
        end
    end
    assign cmd.tgl = tgl_q;

    cov_op_a: cover property (@(posedge sclk) disable iff (cs_n) st_q == SFCI_ACTIVE);
    cov_sb_a: cover property (@(posedge sclk) disable iff (cs_n) st_q == SFCI_STANDBY);
    standby_hiz_a: assert property (@(negedge sclk) disable iff (cs_n)
        (st_q == SFCI_STANDBY) |=> (dq_oe == 4'h0))
        else $error("output driven in standby");
endmodule : sfci_link
`default_nettype wire

// ===== logic/sfci_pkg.sv
// Shared constants for the serial flash command interface
package sfci_pkg;
    localparam int ADDR_W           = 22;
    localparam logic [21:0] ADDR_MAX = 22'h3F_FFFF;
    localparam int BLK_LSB          = 16;
    localparam int HALF_LSB         = 15;
    localparam int SEC_LSB          = 12;
    localparam logic [5:0] BLK_LAST = 6'h3F;
    localparam logic [5:0] BLK_FIRST = 6'h00;
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ_CMD  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE_CMD  = 8'h01;
    localparam logic [7:0] OP_READ  = 8'h03;
    localparam logic [7:0] OP_FREAD = 8'h0B;
    localparam logic [7:0] OP_PP    = 8'h02;
    localparam logic [7:0] OP_SE    = 8'h20;
    localparam logic [7:0] OP_BE32  = 8'h52;
    localparam logic [7:0] OP_BE    = 8'hD8;
    localparam logic [7:0] OP_CE    = 8'h60;
    localparam logic [7:0] OP_CE2   = 8'hC7;
    localparam logic [7:0] OP_QEN   = 8'h35;
    localparam logic [7:0] OP_QEX   = 8'hF5;
    localparam logic [3:0] CNT_RST  = 4'h0;
    typedef enum logic [1:0] {
        SFCI_IDLE    = 2'b00,
        SFCI_OPCODE  = 2'b01,
        SFCI_ACTIVE  = 2'b10,
        SFCI_STANDBY = 2'b11
    } sfci_state_e;
    typedef enum logic [1:0] {
        SFCI_K_NONE  = 2'b00,
        SFCI_K_READ  = 2'b01,
        SFCI_K_WRITE = 2'b10
    } sfci_kind_e;
endpackage : sfci_pkg

// ===== logic/sfci_top.sv
// Top of the serial flash command interface
`timescale 1ns/1ps
`default_nettype none
module sfci_top
    import sfci_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic [3:0]  dq_i,
    output logic [3:0]       dq_o,
    output logic [3:0]       dq_oe,
    input  wire logic        busy,
    output logic             quad_mode_q,
    output logic             pin_prot_en_q,
    output logic             cmd_stb_q,
    output logic [7:0]       cmd_op_q,
    output logic [21:0]      cmd_addr_q,
    output logic [5:0]       blk_q,
    output logic [6:0]       half_q,
    output logic [9:0]       sec_q,
    output logic             sector_lock_unit_q,
    output logic             array_drop_q
);
    sfci_cmd_if cmd ();
    logic [2:0] tgl_s_q;
    logic       busy_l1_q, busy_l2_q, busy_r1_q, busy_r2_q;

    // Link side; clock modes 0 and 3 both sample on rising edges
    sfci_link u_link (
        .rst       (rst),
        .sclk      (sclk),
        .cs_n      (cs_n),
        .dq_i      (dq_i),
        .dq_o      (dq_o),
        .dq_oe     (dq_oe),
        .busy      (busy_l2_q),
        .cmd       (cmd)
    );

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            busy_l1_q <= 1'b0;
            busy_l2_q <= 1'b0;
        end else begin
            busy_l1_q <= busy;
            busy_l2_q <= busy_l1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Toggle synchroniser for completed commands
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) tgl_s_q <= 3'b000;
        else tgl_s_q <= {tgl_s_q[1:0], cmd.tgl};
    end

    // Busy pin into the core clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_r1_q <= 1'b0;
            busy_r2_q <= 1'b0;
        end else begin
            busy_r1_q <= busy;
            busy_r2_q <= busy_r1_q;
        end
    end

    function automatic logic is_array(input logic [7:0] o);
        is_array = (o == OP_READ) || (o == OP_FREAD) || (o == OP_PP) || (o == OP_SE)
                || (o == OP_BE32) || (o == OP_BE) || (o == OP_CE) || (o == OP_CE2);
    endfunction : is_array

    wire new_cmd = tgl_s_q[2] ^ tgl_s_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Mode, decode and busy gating
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            quad_mode_q        <= 1'b0;
            pin_prot_en_q      <= 1'b1;
            cmd_stb_q          <= 1'b0;
            cmd_op_q           <= 8'h00;
            cmd_addr_q         <= 22'h00_0000;
            blk_q              <= 6'h00;
            half_q             <= 7'h00;
            sec_q              <= 10'h000;
            sector_lock_unit_q <= 1'b0;
            array_drop_q       <= 1'b0;
        end else begin
            cmd_stb_q    <= 1'b0;
            array_drop_q <= 1'b0;
            pin_prot_en_q <= ~quad_mode_q;
            if (new_cmd) begin
                if (cmd.op == OP_QEN) quad_mode_q <= 1'b1;
                if (cmd.op == OP_QEX) quad_mode_q <= 1'b0;
                if (busy_r2_q && is_array(cmd.op)) begin
                    array_drop_q <= 1'b1;
                end else begin
                    cmd_stb_q  <= 1'b1;
                    cmd_op_q   <= cmd.op;
                    cmd_addr_q <= cmd.addr & ADDR_MAX;
                    blk_q      <= cmd.addr[21:BLK_LSB];
                    half_q     <= cmd.addr[21:HALF_LSB];
                    sec_q      <= cmd.addr[21:SEC_LSB];
                    sector_lock_unit_q <= (cmd.addr[21:BLK_LSB] == BLK_FIRST)
                                       || (cmd.addr[21:BLK_LSB] == BLK_LAST);
                end
            end
        end
    end

    busy_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
        (new_cmd && busy_r2_q && is_array(cmd.op)) |=> (array_drop_q && !cmd_stb_q))
        else $error("array access not dropped while busy");
    quad_on_a: assert property (@(posedge ref_clk) disable iff (rst)
        (new_cmd && cmd.op == OP_QEN) |=> quad_mode_q)
        else $error("four-line mode not entered");
    quad_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        (new_cmd && cmd.op == OP_QEX) |=> !quad_mode_q)
        else $error("four-line mode not left");
    prot_a: assert property (@(posedge ref_clk) disable iff (rst)
        quad_mode_q |=> !pin_prot_en_q)
        else $error("pin protection active in four-line mode");
    blk_map_a: assert property (@(posedge ref_clk) disable iff (rst)
        cmd_stb_q |-> (blk_q == cmd_addr_q[21:BLK_LSB] && half_q == cmd_addr_q[21:HALF_LSB]
                       && sec_q == cmd_addr_q[21:SEC_LSB]))
        else $error("block map mismatch");
    lock_unit_a: assert property (@(posedge ref_clk) disable iff (rst)
        cmd_stb_q |-> (sector_lock_unit_q == (blk_q == BLK_FIRST || blk_q == BLK_LAST)))
        else $error("lock unit wrong");
    hiz_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
        $past(cs_n, 3) && cs_n |-> (dq_oe == 4'h0))
        else $error("driving while deselected");
    strobe_one_a: assert property (@(posedge ref_clk) disable iff (rst)
        cmd_stb_q |=> !cmd_stb_q)
        else $error("strobe longer than one cycle");
    cov_quad_a: cover property (@(posedge ref_clk) disable iff (rst) $rose(quad_mode_q));
    cov_drop_a: cover property (@(posedge ref_clk) disable iff (rst) array_drop_q);
    cov_cmd_a: cover property (@(posedge ref_clk) disable iff (rst) cmd_stb_q);
endmodule : sfci_top
`default_nettype wire

// ===== sim/sfci_host_model.sv
// Host controller model that drives chip select, serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module sfci_host_model (
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      dq_i,
    input  wire logic [3:0] dq_o,
    input  wire logic [3:0] dq_oe
);
    localparam time HALF  = 32ns;
    localparam time DESEL = 240ns;
    logic [7:0] rx_q;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        dq_i = 4'hD;
        rx_q = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // One frame: nbits sent MSB first, then nrd clocks of reply
    task automatic frame(input logic [31:0] bits, input int nbits, input int nrd,
                         input logic quad, input logic cpol);
        int step;
        step = quad ? 4 : 1;
        sclk = cpol;
        #(HALF);
        cs_n = 1'b0;
        for (int i = 0; i < nbits + nrd * step; i += step) begin
            sclk = 1'b0;
            if (i >= nbits)
                dq_i = {quad ? ~dq_i[3:2] : 2'b11, ~dq_i[1:0]};
            else if (quad)
                dq_i = bits[31 - i -: 4];
            else
                dq_i = {2'b11, ~dq_i[1], bits[31 - i]};
            #(HALF);
            sclk = 1'b1;
            if (i >= nbits)
                rx_q = {rx_q[6:0], dq_oe[1] ? dq_o[1] : ~dq_o[1]};
            #(HALF);
        end
        sclk = cpol;
        #(HALF);
        cs_n = 1'b1;
        dq_i = {2'b11, ~dq_i[1:0]};
        #(DESEL);
    endtask : frame
endmodule : sfci_host_model
`default_nettype wire

// ===== sim/sfci_top_tb.sv
// Self-checking bench for the serial flash command interface
`timescale 1ns/1ps
`default_nettype none
module sfci_top_tb
    import sfci_pkg::*;
;
    logic ref_clk, rst, sclk, cs_n, busy, quad_mode_q, pin_prot_en_q, cmd_stb_q;
    logic sector_lock_unit_q, array_drop_q;
    logic [3:0]  dq_i, dq_o, dq_oe;
    logic [7:0]  cmd_op_q;
    logic [21:0] cmd_addr_q;
    logic [5:0]  blk_q;
    logic [6:0]  half_q;
    logic [9:0]  sec_q;
    int stb_n = 0, drop_n = 0, oe_n = 0, bad_count = 0, n_compared = 0;
    localparam logic [21:0] AT [4] = '{22'h3F_F123, 22'h00_0FFF, 22'h01_0000, 22'h3E_FFFF};
    localparam logic [7:0]  OT [4] = '{OP_SE, OP_BE32, OP_BE, OP_SE};
    sfci_top dut_u (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe(dq_oe), .busy(busy), .quad_mode_q(quad_mode_q),
        .pin_prot_en_q(pin_prot_en_q), .cmd_stb_q(cmd_stb_q), .cmd_op_q(cmd_op_q),
        .cmd_addr_q(cmd_addr_q), .blk_q(blk_q), .half_q(half_q), .sec_q(sec_q),
        .sector_lock_unit_q(sector_lock_unit_q), .array_drop_q(array_drop_q));
    sfci_host_model host_u (.sclk(sclk), .cs_n(cs_n), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe(dq_oe));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (cmd_stb_q === 1'b1)
            stb_n++;
        if (array_drop_q === 1'b1)
            drop_n++;
        if (dq_oe !== 4'h0)
            oe_n++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic set_busy(input logic b);
        @(posedge ref_clk);
        #1 busy = b;
    endtask : set_busy
    task automatic t_cmd(input logic [7:0] op, input int nb, input logic quad,
                         input logic cpol, input int n_exp);
        int s0;
        s0 = stb_n;
        host_u.frame({op, 24'h00_0000}, nb, 0, quad, cpol);
        chk(stb_n - s0, n_exp);
        if (n_exp > 0)
            chk(cmd_op_q, op);
    endtask : t_cmd
    task automatic t_invalid;
        int s0, o0;
        s0 = stb_n;
        o0 = oe_n;
        host_u.frame({8'hFF, OP_WREN, 16'h0000}, 16, 8, 1'b0, 1'b0);
        chk(stb_n - s0, 0);
        chk(oe_n - o0, 0);
    endtask : t_invalid
    task automatic t_addr;
        logic [21:0] a;
        for (int i = 0; i < 4; i++) begin
            a = AT[i];
            host_u.frame({OT[i], 2'b00, a}, 32, 0, 1'b0, 1'b0);
            chk(cmd_addr_q, a);
            chk(blk_q, a[21:16]);
            chk(half_q, a[21:15]);
            chk(sec_q, a[21:12]);
            chk(sector_lock_unit_q, a[21:16] == BLK_FIRST || a[21:16] == BLK_LAST);
        end
    endtask : t_addr
    task automatic t_busy;
        int s0, d0;
        set_busy(1'b1);
        for (int i = 0; i < 2; i++) begin
            s0 = stb_n;
            d0 = drop_n;
            host_u.frame({i ? OP_BE : OP_SE, 24'h12_3456}, 32, 0, 1'b0, 1'b0);
            chk(drop_n - d0, 1);
            chk(stb_n - s0, 0);
        end
        set_busy(1'b0);
    endtask : t_busy
    task automatic t_status;
        int o0;
        for (int b = 0; b < 2; b++) begin
            set_busy(b[0]);
            o0 = oe_n;
            host_u.frame({OP_STATUS_READ_CMD, 24'h00_0000}, 8, 8, 1'b0, 1'b0);
            chk(host_u.rx_q[0], b[0]);
            chk(oe_n > o0, 1);
        end
        set_busy(1'b0);
    endtask : t_status
    task automatic t_quad;
        host_u.frame({OP_QEN, 24'h00_0000}, 8, 0, 1'b0, 1'b0);
        chk(quad_mode_q, 1);
        chk(pin_prot_en_q, 0);
        t_cmd(OP_WREN, 8, 1'b1, 1'b0, 1);
        host_u.frame({OP_SE, 2'b00, AT[0]}, 32, 0, 1'b1, 1'b1);
        chk(cmd_addr_q, AT[0]);
        host_u.frame({OP_STATUS_READ_CMD, 24'h00_0000}, 8, 2, 1'b1, 1'b0);
        chk(host_u.rx_q[0], 0);
        host_u.frame({OP_QEX, 24'h00_0000}, 8, 0, 1'b1, 1'b0);
        chk(quad_mode_q, 0);
        chk(pin_prot_en_q, 1);
    endtask : t_quad
    task automatic final_report;
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        busy = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        chk(pin_prot_en_q, 1);
        t_cmd(OP_WREN, 8, 1'b0, 1'b0, 1);
        t_cmd(OP_WRDI, 8, 1'b0, 1'b1, 1);
        t_cmd(OP_WREN, 7, 1'b0, 1'b0, 0);
        t_invalid;
        t_addr;
        t_busy;
        t_status;
        t_quad;
        final_report;
    end
    initial begin
        #500us;
        bad_count++;
        final_report;
    end
endmodule : sfci_top_tb
`default_nettype wire
